/* File: core/hex_ascii.sv */
// nibble to ascii hexadecimal character
`default_nettype none
module hex_ascii (
   // value
   input wire logic [3:0] nibble,
   // character
   output logic [7:0] ascii
);
   always_comb begin
      if (nibble < 4'hA) begin
         ascii = 8'h30 + {4'h0, nibble};
      end else begin
         ascii = 8'h37 + {4'h0, nibble};
      end
   end
endmodule
`default_nettype wire

/* File: core/reply_fifo.sv */
// byte fifo between reply generator and link
`default_nettype none
module reply_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_t;
   fifo_t f_q;
   fifo_t f_d;
   logic full;
   logic empty;

   assign full = (f_q.wr[AW] != f_q.rd[AW]) && (f_q.wr[AW-1:0] == f_q.rd[AW-1:0]);
   assign empty = f_q.wr == f_q.rd;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = f_q.mem[f_q.rd[AW-1:0]];

   always_comb begin
      f_d = f_q;
      if (in_valid && !full) begin
         f_d.mem[f_q.wr[AW-1:0]] = in_data;
         f_d.wr = f_q.wr + 1'b1;
      end
      if (out_ready && !empty) begin
         f_d.rd = f_q.rd + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end
endmodule
`default_nettype wire

/* File: core/weigh_serial_status_responder.sv */
// status, query, format and monitor replies of the serial command interpreter
`include "weigh_regs.svh"
`default_nettype none
module weigh_serial_status_responder (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // decoded command from the framing engine
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [3:0] cmd_kind,
   input wire logic [7:0] cmd_sub,
   input wire logic [15:0] cmd_mask,
   input wire logic [5:0] cmd_format,
   input wire logic [15:0] cmd_addr,
   input wire logic [23:0] cmd_echo,
   input wire logic [1:0] cmd_echo_len,
   input wire logic cmd_fail,
   input wire logic [7:0] cmd_fail_code,
   // instrument state from on-chip logic
   input wire logic [7:0] led_byte1,
   input wire logic [7:0] led_byte2,
   input wire logic [7:0] relay_state,
   input wire logic [23:0] load_counts,
   input wire logic [23:0] gross_weight,
   input wire logic [23:0] net_weight,
   input wire logic [23:0] peak_gross,
   input wire logic [23:0] total_net,
   input wire logic [23:0] weight_change_rate,
   // pins
   input wire logic [7:0] rear_switch_pins,
   input wire logic [7:0] internal_switch_pins,
   input wire logic [7:0] external_input_pins,
   // reply byte stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_last,
   // stored settings
   output logic [4:0] format_sel,
   output logic format_print_trigger,
   output logic monitor_active
);
   weigh_pkg::state_t s_q;
   weigh_pkg::state_t s_d;
   logic push;
   logic fifo_ready;
   logic [7:0] lit;
   logic hex_en;
   logic [3:0] nib;
   logic [7:0] hex_ch;
   logic [7:0] byte_out;
   logic last_out;
   logic [15:0] grp_now;
   logic change;

   function automatic logic [3:0] nib16(input logic [15:0] v, input logic [6:0] k);
      logic [15:0] t;
      t = v << {k[1:0], 2'b00};
      return t[15:12];
   endfunction

   function automatic logic [3:0] nib24(input logic [23:0] v, input logic [6:0] k);
      logic [23:0] t;
      t = v << {k[2:0], 2'b00};
      return t[23:20];
   endfunction

   function automatic logic [7:0] unit_ch(input logic kg, input logic second);
      logic [7:0] c;
      if (kg) begin
         c = second ? `CH_KG_2 : `CH_KG_1;
      end else begin
         c = second ? `CH_LB_2 : `CH_LB_1;
      end
      return c;
   endfunction

   hex_ascii u_hex (
      .nibble(nib),
      .ascii(hex_ch)
   );

   // monitored group value, live
   always_comb begin
      unique case (s_q.grp)
         weigh_pkg::GRP_RELAY: grp_now = {8'h00, relay_state};
         weigh_pkg::GRP_SWITCH: grp_now = {s_q.rear_s, s_q.int_s};
         weigh_pkg::GRP_LED: grp_now = {led_byte1, led_byte2};
         weigh_pkg::GRP_NONE: grp_now = 16'h0000;
      endcase
   end

   // only masked items count as a change
   assign change = (s_q.grp != weigh_pkg::GRP_NONE) && (((grp_now ^ s_q.last) & s_q.mask) != 16'h0000);

   // byte generator
   always_comb begin
      lit = 8'h00;
      hex_en = 1'b0;
      nib = 4'h0;
      unique case (s_q.phase)
         weigh_pkg::PH_HEAD: begin
            // echo of the received framing
            unique case (s_q.idx)
               7'h00: lit = `CH_START;
               7'h01: lit = s_q.addr[15:8];
               7'h02: lit = s_q.addr[7:0];
               7'h03: lit = s_q.echo[23:16];
               7'h04: lit = s_q.echo[15:8];
               default: lit = s_q.echo[7:0];
            endcase
         end
         weigh_pkg::PH_BODY: begin
            hex_en = 1'b1;
            unique case (s_q.kind)
               weigh_pkg::K_STATUS: nib = nib16(s_q.led, s_q.idx);
               weigh_pkg::K_SWITCH: nib = nib16({s_q.rear, s_q.intl}, s_q.idx);
               weigh_pkg::K_LOAD: nib = nib24(s_q.counts, s_q.idx);
               weigh_pkg::K_REMOTE: nib = nib16({s_q.external_input_level_query, 8'h00}, s_q.idx);
               weigh_pkg::K_REPORT: nib = nib16(s_q.last, s_q.idx);
               weigh_pkg::K_MONITOR: begin
                  // present status then hash and bell
                  if (s_q.idx < 7'h04) begin
                     nib = nib16(s_q.last, s_q.idx);
                  end else begin
                     hex_en = 1'b0;
                     lit = (s_q.idx == 7'h04) ? `CH_HASH : `CH_BEL;
                  end
               end
               weigh_pkg::K_ERROR: begin
                  // error letter and two digits
                  if (s_q.idx == 7'h00) begin
                     hex_en = 1'b0;
                     lit = `CH_ERR;
                  end else begin
                     nib = (s_q.idx == 7'h01) ? s_q.err[7:4] : s_q.err[3:0];
                  end
               end
               weigh_pkg::K_QUERY: begin
                  // fixed query layout
                  if (s_q.idx < 7'h06) begin
                     nib = nib24(s_q.gross, s_q.idx);
                  end else if (s_q.idx < 7'h08) begin
                     hex_en = 1'b0;
                     lit = unit_ch(s_q.led[8 + `LED1_KG_BIT], s_q.idx[0]);
                  end else if (s_q.idx < 7'h0E) begin
                     nib = nib24(s_q.net, s_q.idx - 7'h08);
                  end else if (s_q.idx < 7'h10) begin
                     hex_en = 1'b0;
                     lit = unit_ch(s_q.led[8 + `LED1_KG_BIT], s_q.idx[0]);
                  end else if (s_q.idx < 7'h16) begin
                     nib = nib24(s_q.peak, s_q.idx - 7'h10);
                  end else if (s_q.idx < 7'h18) begin
                     hex_en = 1'b0;
                     lit = unit_ch(s_q.led[8 + `LED1_KG_BIT], s_q.idx[0]);
                  end else if (s_q.idx < 7'h1E) begin
                     nib = nib24(s_q.counts, s_q.idx - 7'h18);
                  end else if (s_q.idx < 7'h24) begin
                     nib = nib24(s_q.total, s_q.idx - 7'h1E);
                  end else if (s_q.idx < 7'h26) begin
                     hex_en = 1'b0;
                     lit = unit_ch(s_q.led[8 + `LED1_KG_BIT], s_q.idx[0]);
                  end else if (s_q.idx < 7'h2C) begin
                     nib = nib24(s_q.rate, s_q.idx - 7'h26);
                  end else if (s_q.idx < 7'h2E) begin
                     hex_en = 1'b0;
                     lit = unit_ch(s_q.led[8 + `LED1_KG_BIT], s_q.idx[0]);
                  end else if (s_q.idx < 7'h3A) begin
                     hex_en = 1'b0;
                     lit = `CH_ZERO;
                  end else if (s_q.idx < 7'h3E) begin
                     nib = nib16(s_q.led, s_q.idx - 7'h3A);
                  end else begin
                     nib = nib16({s_q.relay, 8'h00}, s_q.idx - 7'h3E);
                  end
               end
               weigh_pkg::K_ACK: hex_en = 1'b0;
               default: hex_en = 1'b0;
            endcase
         end
         weigh_pkg::PH_TAIL: lit = (s_q.idx == 7'h00) ? `CH_CR : `CH_LF;
         weigh_pkg::PH_IDLE: lit = 8'h00;
      endcase
   end

   assign byte_out = hex_en ? hex_ch : lit;
   assign last_out = (s_q.phase == weigh_pkg::PH_TAIL) && (s_q.idx == 7'h01);
   assign push = (s_q.phase != weigh_pkg::PH_IDLE) && fifo_ready;
   assign cmd_ready = s_q.phase == weigh_pkg::PH_IDLE;

   // sequencing and command acceptance
   always_comb begin
      weigh_pkg::group_t g;
      logic lock;
      g = weigh_pkg::GRP_NONE;
      lock = (s_q.rear_s & `REAR_CMD_LOCK) != 8'h00;
      s_d = s_q;
      // pins pass two flops; the first is read only by the second
      s_d.rear_m = rear_switch_pins;
      s_d.rear_s = s_q.rear_m;
      s_d.int_m = internal_switch_pins;
      s_d.int_s = s_q.int_m;
      s_d.rem_m = external_input_pins;
      s_d.rem_s = s_q.rem_m;
      if (push) begin
         s_d.idx = s_q.idx + 7'h01;
         unique case (s_q.phase)
            weigh_pkg::PH_HEAD: begin
               if (s_q.idx == 7'h02 + {5'h00, s_q.echo_len}) begin
                  s_d.idx = 7'h00;
                  s_d.phase = (s_q.len == 7'h00) ? weigh_pkg::PH_TAIL : weigh_pkg::PH_BODY;
               end
            end
            weigh_pkg::PH_BODY: begin
               if (s_q.idx == s_q.len - 7'h01) begin
                  s_d.idx = 7'h00;
                  s_d.phase = weigh_pkg::PH_TAIL;
               end
            end
            weigh_pkg::PH_TAIL: begin
               if (s_q.idx == 7'h01) begin
                  s_d.idx = 7'h00;
                  s_d.phase = weigh_pkg::PH_IDLE;
               end
            end
            weigh_pkg::PH_IDLE: s_d.idx = 7'h00;
         endcase
      end else if (s_q.phase == weigh_pkg::PH_IDLE && cmd_valid) begin
         // snapshot so a long reply stays self-consistent
         s_d.phase = weigh_pkg::PH_HEAD;
         s_d.idx = 7'h00;
         s_d.addr = cmd_addr;
         s_d.echo = cmd_echo;
         s_d.echo_len = cmd_echo_len;
         s_d.led = {led_byte1, led_byte2};
         s_d.rear = s_q.rear_s;
         s_d.intl = s_q.int_s;
         s_d.external_input_level_query = s_q.rem_s;
         s_d.relay = relay_state;
         s_d.counts = load_counts;
         s_d.gross = gross_weight;
         s_d.net = net_weight;
         s_d.peak = peak_gross;
         s_d.total = total_net;
         s_d.rate = weight_change_rate;
         s_d.kind = weigh_pkg::K_ERROR;
         s_d.len = `LEN_ERROR;
         s_d.err = `ERR_SUBCMD;
         if (cmd_fail) begin
            s_d.err = cmd_fail_code;
         end else begin
            unique case (cmd_kind)
               `CMD_STATUS: begin
                  s_d.kind = weigh_pkg::K_STATUS;
                  s_d.len = `LEN_STATUS;
               end
               `CMD_SWITCH: begin
                  s_d.kind = weigh_pkg::K_SWITCH;
                  s_d.len = `LEN_SWITCH;
               end
               `CMD_LOAD: begin
                  s_d.kind = weigh_pkg::K_LOAD;
                  s_d.len = `LEN_LOAD;
               end
               `CMD_REMOTE: begin
                  s_d.kind = weigh_pkg::K_REMOTE;
                  s_d.len = `LEN_REMOTE;
               end
               `CMD_QUERY: begin
                  s_d.kind = weigh_pkg::K_QUERY;
                  s_d.len = `LEN_QUERY;
               end
               `CMD_FORMAT: begin
                  // lockout bars settings, queries still answered
                  if (lock) begin
                     s_d.err = `ERR_LOCKOUT;
                  end else if ((cmd_format & `FMT_DATA_MASK) == 6'h00) begin
                     s_d.err = `ERR_FORMAT;
                  end else begin
                     s_d.fmt = cmd_format;
                     s_d.kind = weigh_pkg::K_ACK;
                     s_d.len = 7'h00;
                  end
               end
               `CMD_MONITOR: begin
                  unique case (cmd_sub)
                     `CH_RELAY: g = weigh_pkg::GRP_RELAY;
                     `CH_SWITCH: g = weigh_pkg::GRP_SWITCH;
                     `CH_LED: g = weigh_pkg::GRP_LED;
                     default: g = weigh_pkg::GRP_NONE;
                  endcase
                  if (lock) begin
                     s_d.err = `ERR_LOCKOUT;
                  end else if ((s_q.rear_s & `REAR_MULTIDROP) != 8'h00) begin
                     s_d.err = `ERR_MULTIDROP;
                  end else if (g == weigh_pkg::GRP_NONE) begin
                     s_d.err = `ERR_SUBCMD;
                  end else if (cmd_mask == 16'h0000) begin
                     // zero mask on the watched group ends monitoring
                     if (g == s_q.grp) begin
                        s_d.grp = weigh_pkg::GRP_NONE;
                     end
                     s_d.kind = weigh_pkg::K_ACK;
                     s_d.len = 7'h00;
                  end else begin
                     // a new subscription replaces the old one
                     s_d.grp = g;
                     s_d.msub = cmd_sub;
                     s_d.mask = cmd_mask;
                     s_d.maddr = cmd_addr;
                     unique case (g)
                        weigh_pkg::GRP_RELAY: s_d.last = {8'h00, relay_state};
                        weigh_pkg::GRP_SWITCH: s_d.last = {s_q.rear_s, s_q.int_s};
                        default: s_d.last = {led_byte1, led_byte2};
                     endcase
                     s_d.kind = weigh_pkg::K_MONITOR;
                     s_d.len = `LEN_MON;
                  end
               end
               default: s_d.err = `ERR_SUBCMD;
            endcase
         end
         if (s_d.kind == weigh_pkg::K_ERROR) begin
            s_d.echo_len = 2'h0;
         end
      end else if (s_q.phase == weigh_pkg::PH_IDLE && change) begin
         // unsolicited report; commands win when both wait
         s_d.phase = weigh_pkg::PH_HEAD;
         s_d.idx = 7'h00;
         s_d.kind = weigh_pkg::K_REPORT;
         s_d.len = `LEN_REPORT;
         s_d.addr = s_q.maddr;
         s_d.echo = {`CH_MON, s_q.msub, 8'h00};
         s_d.echo_len = 2'h2;
         s_d.last = grp_now;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.fmt <= `FMT_DEFAULT;
      end else begin
         s_q <= s_d;
      end
   end

   reply_fifo #(
      .WIDTH(9),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(s_q.phase != weigh_pkg::PH_IDLE),
      .in_ready(fifo_ready),
      .in_data({last_out, byte_out}),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data({tx_last, tx_data})
   );

   assign format_sel = s_q.fmt[4:0];
   assign format_print_trigger = s_q.fmt[5];
   assign monitor_active = s_q.grp != weigh_pkg::GRP_NONE;
endmodule
`default_nettype wire

/* File: include/weigh_pkg.sv */
// types shared by the status responder
`default_nettype none
package weigh_pkg;
   typedef enum logic [1:0] {PH_IDLE, PH_HEAD, PH_BODY, PH_TAIL} phase_t;
   typedef enum logic [1:0] {GRP_NONE, GRP_RELAY, GRP_SWITCH, GRP_LED} group_t;
   typedef enum logic [3:0] {
      K_STATUS, K_SWITCH, K_LOAD, K_REMOTE, K_QUERY, K_ACK, K_MONITOR, K_REPORT, K_ERROR
   } reply_t;
   typedef struct packed {
      phase_t phase;
      reply_t kind;
      logic [6:0] idx;
      logic [6:0] len;
      logic [15:0] addr;
      logic [23:0] echo;
      logic [1:0] echo_len;
      logic [7:0] err;
      logic [7:0] rear_m;
      logic [7:0] rear_s;
      logic [7:0] int_m;
      logic [7:0] int_s;
      logic [7:0] rem_m;
      logic [7:0] rem_s;
      logic [15:0] led;
      logic [7:0] rear;
      logic [7:0] intl;
      logic [7:0] external_input_level_query;
      logic [7:0] relay;
      logic [23:0] counts;
      logic [23:0] gross;
      logic [23:0] net;
      logic [23:0] peak;
      logic [23:0] total;
      logic [23:0] rate;
      logic [5:0] fmt;
      group_t grp;
      logic [7:0] msub;
      logic [15:0] mask;
      logic [15:0] last;
      logic [15:0] maddr;
   } state_t;
endpackage
`default_nettype wire

/* File: include/weigh_regs.svh */
// constants for the weighing serial status responder
`ifndef WEIGH_REGS_SVH
`define WEIGH_REGS_SVH
`define CMD_STATUS 4'h0
`define CMD_SWITCH 4'h1
`define CMD_LOAD 4'h2
`define CMD_REMOTE 4'h3
`define CMD_QUERY 4'h4
`define CMD_FORMAT 4'h5
`define CMD_MONITOR 4'h6
`define LED1_KG_BIT 7
`define REAR_MULTIDROP 8'h80
`define REAR_CMD_LOCK 8'h40
`define FMT_DATA_MASK 6'h1F
`define FMT_DEFAULT 6'h3F
`define LEN_STATUS 7'h04
`define LEN_SWITCH 7'h04
`define LEN_LOAD 7'h06
`define LEN_REMOTE 7'h02
`define LEN_QUERY 7'h40
`define LEN_MON 7'h06
`define LEN_REPORT 7'h04
`define LEN_ERROR 7'h03
`define CH_START 8'h3E
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_HASH 8'h23
`define CH_BEL 8'h07
`define CH_ZERO 8'h30
`define CH_ERR 8'h4E
`define CH_MON 8'h4D
`define CH_RELAY 8'h52
`define CH_SWITCH 8'h44
`define CH_LED 8'h4C
`define CH_LB_1 8'h4C
`define CH_LB_2 8'h62
`define CH_KG_1 8'h4B
`define CH_KG_2 8'h67
`define ERR_LOCKOUT 8'h21
`define ERR_FORMAT 8'h22
`define ERR_SUBCMD 8'h23
`define ERR_MULTIDROP 8'h24
`define FIFO_DEPTH 16
`endif

/* File: tb/weigh_host_model.sv */
// host end of the reply stream: collects bytes, prompt or slow
`default_nettype none
module weigh_host_model (
   // clock
   input wire logic sys_clk,
   // stream
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   // pacing, slow drains a quarter rate so the fifo fills
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got[$];
   int seed = 32'hCE68;
   int n_last = 0;
   always @(posedge sys_clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      if (tx_valid && tx_ready && tx_last) n_last++;
      tx_ready <= !slow || ($random(seed) & 3) == 0;
   end
endmodule
`default_nettype wire

/* File: tb/weigh_serial_status_responder_bench.sv */
// self-checking bench for the status responder
`default_nettype none
module weigh_serial_status_responder_bench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
   logic sys_clk, cmd_ready, tx_valid, tx_ready, tx_last, fpt, mon, reset = 1'h1;
   logic cmd_valid = 1'h0, fail = 1'h0, slow = 1'h0;
   logic [3:0] kind = 4'h0;
   logic [7:0] sub = 8'h0, code = 8'h0, led1 = 8'h0, led2 = 8'h0, relay = 8'h0, tx_data;
   logic [7:0] rear = 8'h0, intl = 8'h0, ext = 8'h0;
   logic [15:0] mask = 16'h0, addr = 16'h3130;
   logic [5:0] fmt = 6'h0;
   logic [4:0] fsel;
   logic [1:0] elen = 2'h0;
   logic [23:0] v[6] = '{default: 24'h0};
   logic [7:0] want[$];
   int ord[6] = '{1, 2, 3, 0, 4, 5};
   logic [34:0] et[6] = '{{4'h5, 8'h00, 6'h20, 8'h00, 1'h0, 8'h22},
      {4'h5, 8'h00, 6'h1F, 8'h40, 1'h0, 8'h21}, {4'h6, 8'h52, 6'h00, 8'h80, 1'h0, 8'h24},
      {4'h6, 8'h58, 6'h00, 8'h00, 1'h0, 8'h23}, {4'hF, 8'h00, 6'h00, 8'h00, 1'h0, 8'h23},
      {4'h0, 8'h00, 6'h00, 8'h00, 1'h1, 8'h57}};
   int num_errors = 0, n_checks = 0, seed = 32'hCE68, i, j;
   weigh_serial_status_responder dut (.sys_clk, .reset, .cmd_valid, .cmd_ready, .cmd_kind(kind),
      .cmd_sub(sub), .cmd_mask(mask), .cmd_format(fmt), .cmd_addr(addr), .cmd_echo(24'h515253),
      .cmd_echo_len(elen), .cmd_fail(fail), .cmd_fail_code(code), .led_byte1(led1),
      .led_byte2(led2), .relay_state(relay), .load_counts(v[0]), .gross_weight(v[1]),
      .net_weight(v[2]), .peak_gross(v[3]), .total_net(v[4]), .weight_change_rate(v[5]),
      .rear_switch_pins(rear), .internal_switch_pins(intl), .external_input_pins(ext),
      .tx_valid, .tx_ready, .tx_data, .tx_last, .format_sel(fsel), .format_print_trigger(fpt),
      .monitor_active(mon));
   weigh_host_model host (.sys_clk, .tx_valid, .tx_ready, .tx_data, .tx_last, .slow);
   task automatic hx(input logic [7:0] b);
      want.push_back(b[7:4] < 4'hA ? 8'h30 + 8'(b[7:4]) : 8'h37 + 8'(b[7:4]));
      want.push_back(b[3:0] < 4'hA ? 8'h30 + 8'(b[3:0]) : 8'h37 + 8'(b[3:0]));
   endtask
   task automatic head(input logic e);
      want = '{8'h3E, addr[15:8], addr[7:0]};
      for (int k = 0; k < 32'(elen) && !e; k++) want.push_back(8'h51 + 8'(k));
   endtask
   task automatic tail();
      want = {want, 8'h0D, 8'h0A};
   endtask
   task automatic summarize();
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rx();
      int t;
      t = 0;
      while (host.got.size() < want.size() && t < 3000) begin
         @(posedge sys_clk);
         t++;
      end
      // settle time so that a stray extra byte is also seen
      repeat (30) @(posedge sys_clk);
      `CHK("length", want.size(), host.got.size())
      foreach (want[n]) if (n < host.got.size()) `CHK("byte", want[n], host.got[n])
      `CHK("last_count", 32'(want.size() != 0), host.n_last)
      host.got = {};
      host.n_last = 0;
   endtask
   task automatic cmd(input logic [3:0] k, input logic [7:0] s, input logic [15:0] m,
         input logic [5:0] f);
      @(negedge sys_clk);
      while (cmd_ready !== 1'h1) @(negedge sys_clk);
      @(posedge sys_clk);
      kind <= k;
      sub <= s;
      mask <= m;
      fmt <= f;
      cmd_valid <= 1'h1;
      // hold the offer until an edge that sees ready high
      do @(posedge sys_clk); while (cmd_ready !== 1'h1);
      cmd_valid <= 1'h0;
      rx();
   endtask
   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (30000) @(posedge sys_clk);
      num_errors++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'h0;
      @(posedge sys_clk);
      `CHK("fmt_reset", 6'h3F, {fpt, fsel})
      for (i = 0; i < 15; i++) begin
         {led1, led2, relay, rear, intl, ext} <= 48'({$random(seed), $random(seed)});
         foreach (v[n]) v[n] <= 24'($random(seed));
         elen <= 2'(i);
         slow <= i[0];
         addr <= 16'h3130 + 16'(i);
         repeat (4) @(posedge sys_clk);
         head(1'h0);
         if (i % 5 == 0) for (j = 0; j < 2; j++) hx(j ? led2 : led1);
         if (i % 5 == 1) for (j = 0; j < 2; j++) hx(j ? intl : rear);
         if (i % 5 == 2) for (j = 2; j >= 0; j--) hx(v[0][8*j +: 8]);
         if (i % 5 == 3) hx(ext);
         if (i % 5 == 4) begin
            foreach (ord[n]) begin
               for (j = 2; j >= 0; j--) hx(v[ord[n]][8*j +: 8]);
               if (ord[n] != 0) want = {want, led1[7] ? 8'h4B : 8'h4C, led1[7] ? 8'h67 : 8'h62};
            end
            repeat (12) want.push_back(8'h30);
            for (j = 0; j < 3; j++) hx(j == 0 ? led1 : j == 1 ? led2 : relay);
         end
         tail();
         cmd(4'(i % 5), 8'h00, 16'h0000, 6'h00);
      end
      slow <= 1'h0;
      rear <= 8'h00;
      elen <= 2'h1;
      repeat (4) @(posedge sys_clk);
      head(1'h0);
      tail();
      cmd(4'h5, 8'h00, 16'h0000, 6'h25);
      `CHK("format", 6'h25, {fpt, fsel})
      for (i = 0; i < 6; i++) begin
         rear <= et[i][16:9];
         fail <= et[i][8];
         code <= et[i][7:0];
         repeat (4) @(posedge sys_clk);
         head(1'h1);
         want.push_back(8'h4E);
         hx(et[i][7:0]);
         tail();
         cmd(et[i][34:31], et[i][30:23], 16'h0001, et[i][22:17]);
      end
      `CHK("format_kept", 6'h25, {fpt, fsel})
      rear <= 8'h00;
      fail <= 1'h0;
      relay <= 8'h11;
      repeat (4) @(posedge sys_clk);
      head(1'h0);
      hx(8'h00);
      hx(8'h11);
      want = {want, 8'h23, 8'h07};
      tail();
      cmd(4'h6, 8'h52, 16'h0004, 6'h00);
      `CHK("mon_on", 1'h1, mon)
      relay <= 8'h13;
      want = {};
      rx();
      relay <= 8'h17;
      want = '{8'h3E, addr[15:8], addr[7:0], 8'h4D, 8'h52};
      hx(8'h00);
      hx(8'h17);
      tail();
      rx();
      head(1'h0);
      tail();
      cmd(4'h6, 8'h52, 16'h0000, 6'h00);
      `CHK("mon_off", 1'h0, mon)
      relay <= 8'h13;
      want = {};
      rx();
      summarize();
   end
endmodule
`default_nettype wire

/* File: tb/weigh_status_checker.sv */
// port assertions for the status responder
`default_nettype none
module weigh_status_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // command port
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [3:0] cmd_kind,
   input wire logic [5:0] cmd_format,
   input wire logic cmd_fail,
   input wire logic [7:0] rear_switch_pins,
   // reply stream
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   // settings
   input wire logic [4:0] format_sel,
   input wire logic format_print_trigger,
   input wire logic monitor_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic take;
   logic [5:0] fmt_q;
   assign take = cmd_valid && cmd_ready;
   always_ff @(posedge sys_clk) if (take) fmt_q <= cmd_format;
   AST_RST_FORMAT: assert property ($fell(reset) |-> {format_print_trigger, format_sel} == 6'h3F)
      else $error("format not defaulted");
   AST_RST_IDLE: assert property ($fell(reset) |-> cmd_ready && !tx_valid && !monitor_active)
      else $error("not idle after reset");
   AST_TAKE_BUSY: assert property (take |=> !cmd_ready)
      else $error("ready during reply");
   AST_FIRST_BYTE: assert property (take && !tx_valid |=> ##1 tx_valid && tx_data == 8'h3E)
      else $error("reply start missing");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("byte lost in stall");
   AST_LAST_LF: assert property (tx_valid && tx_last |-> tx_data == 8'h0A)
      else $error("last byte not line feed");
   AST_FMT_REJECT: assert property (take && cmd_kind == 4'h5 && cmd_format[4:0] == 5'h00 |=>
      ($stable(format_sel) && $stable(format_print_trigger))[*8]) else $error("bad format stored");
   AST_FMT_STORE: assert property (take && cmd_kind == 4'h5 && cmd_format[4:0] != 5'h00 &&
      !rear_switch_pins[6] && !cmd_fail |=> ##[0:3] {format_print_trigger, format_sel} == fmt_q)
      else $error("format not stored");
   cover property (take && cmd_kind == 4'h4);
   cover property (tx_valid && !tx_ready ##1 tx_valid && !tx_ready);
   cover property (take && cmd_kind == 4'h6);
endmodule
bind weigh_serial_status_responder weigh_status_checker chk (.sys_clk, .reset, .cmd_valid,
   .cmd_ready, .cmd_kind, .cmd_format, .cmd_fail, .rear_switch_pins, .tx_valid, .tx_ready, .tx_data,
   .tx_last, .format_sel, .format_print_trigger, .monitor_active);
`default_nettype wire
